// ### rtl/dci_params.svh
// timing counts, field positions and burst figures of the ddr3 command pin link
`ifndef DCI_PARAMS_SVH
`define DCI_PARAMS_SVH

// link clock made by the controller from sys_clk
`define DCI_SYS_PERIOD_NS 4
`define DCI_CK_PERIOD_NS  48
`define DCI_CK_HALF       (`DCI_CK_PERIOD_NS / `DCI_SYS_PERIOD_NS / 2)
`define DCI_CK_HALF_LAST  3'(`DCI_CK_HALF - 1)
`define DCI_CAP_CNT       3'h3

// widths
`define DCI_ROW_W         14
`define DCI_COL_W         10
`define DCI_BANKS         8

// burst figures
`define DCI_BL8_LAST      3'h7
`define DCI_BC4_LAST      3'h3
`define DCI_RD_SKIP       4'h2

// address pin fields
`define DCI_A_AP          10
`define DCI_A_BC          12
`define DCI_BA_RFU        2

// mode register fields
`define DCI_MR0_BL        1:0
`define DCI_BL_OTF        2'h1
`define DCI_BL_BC4        2'h2
`define DCI_MR0_BT        3
`define DCI_MR1_RTT0      2
`define DCI_MR1_RTT1      6
`define DCI_MR1_RTT2      9
`define DCI_MR1_TDQS      11
`define DCI_MR2_RWR       10:9
`define DCI_MR_RST        14'h0000

`endif

// ### rtl/dci_pkg.sv
// types shared by both ends of the ddr3 command pin link
package dci_pkg;

    // {ras_n, cas_n, we_n} with chip select low
    typedef enum logic [2:0] {
        DCI_MRS = 3'h0,
        DCI_REF = 3'h1,
        DCI_PRE = 3'h2,
        DCI_ACT = 3'h3,
        DCI_WR  = 3'h4,
        DCI_RD  = 3'h5,
        DCI_ZQ  = 3'h6,
        DCI_NOP = 3'h7
    } dci_cmd_t;

    typedef enum logic [1:0] {
        DCI_PWR_ON   = 2'h0,
        DCI_PWR_PPD  = 2'h1,
        DCI_PWR_APD  = 2'h2,
        DCI_PWR_SREF = 2'h3
    } dci_pwr_t;

    typedef enum logic [1:0] {
        DCI_BST_IDLE = 2'h0,
        DCI_BST_RD   = 2'h1,
        DCI_BST_WR   = 2'h2
    } dci_bst_t;

    typedef enum logic [1:0] {
        DCI_CST_IDLE = 2'h0,
        DCI_CST_CMD  = 2'h1,
        DCI_CST_WR   = 2'h2,
        DCI_CST_RD   = 2'h3
    } dci_cst_t;

endpackage

// ### rtl/dci_link_if.sv
// pin bundle between the controller end and the dram end
`timescale 1ns/10ps
interface dci_link_if;
    logic       ck;
    logic       ck_n;
    logic       reset_n;
    logic       cke;
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic       odt;
    logic [2:0] ba;
    logic [13:0] a;
    logic       dm;
    // two-way data and strobe, one driver set per end
    logic [7:0] ctl_dq_o;
    logic       ctl_dq_oe;
    logic       ctl_dqs_o;
    logic       ctl_dqs_n_o;
    logic [7:0] dev_dq_o;
    logic       dev_dq_oe;
    logic       dev_dqs_o;
    logic       dev_dqs_n_o;
    logic [7:0] dq;
    logic       dqs;
    logic       dqs_n;

    // wire levels resolved from the dram end enable, controller drive otherwise
    assign ck_n  = ~ck;
    assign dq    = dev_dq_oe ? dev_dq_o : ctl_dq_o;
    assign dqs   = dev_dq_oe ? dev_dqs_o : ctl_dqs_o;
    assign dqs_n = dev_dq_oe ? dev_dqs_n_o : ctl_dqs_n_o;

    modport dev (
        input  ck, ck_n, reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, a, dm, dq, dqs, dqs_n,
        output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_n_o
    );
    modport ctl (
        output ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, a, dm,
        output ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_n_o,
        input  dq, dqs, dqs_n, dev_dq_oe
    );
endinterface

// ### rtl/dci_sync.sv
// two flip-flop synchroniser for pin levels entering sys_clk
`timescale 1ns/10ps
module dci_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    // level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // first stage feeds only the second
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_ff <= '0;
            q       <= '0;
        end
        else
        begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule

// ### rtl/dci_dram_end.sv
// dram end of the ddr3 command pin link: decode, banks, bursts, power and termination
//
// Notes on behaviour
// - sample command and address on ck rise
// - chip select high masks the command
// - ras, cas, we with cs define command
// - cke low enters power-down by bank state
// - self refresh: only cke, exit asynchronously
// - power-down keeps only ck, odt, cke
// - controller keeps cke high during bursts
// - termination only on data, strobe, mask pins
// - odt ignored in self refresh or disabled
// - high mask sample drops that write beat
// - mr1 a11 picks mask or termination strobe
// - controller keeps mr1 a11 low on x16
// - bank bits pick bank or mode register
// - address carries row, column or opcode
// - a10 on access requests auto precharge
// - a10 on precharge selects all banks
// - a12 picks burst eight or chop four
// - reset pin low resets asynchronously
// - strobes edge-aligned on reads, centred on writes
// - strobes only as differential pairs
// - bursts of four or eight, sequential or interleaved
// - activate before access to a bank
// - mrs is all low, ba selects register
`timescale 1ns/10ps
`include "dci_params.svh"
module dci_dram_end (
    // link pins, clocked by the link clock
    dci_link_if.dev            pins,
    // memory array side
    output logic [26:0]        mem_addr,
    output logic               mem_we,
    output logic [7:0]         mem_wdata,
    input  wire logic [7:0]    mem_rdata,
    // status
    output dci_pkg::dci_pwr_t  pwr_state,
    output logic [7:0]         bank_open,
    output logic               term_en,
    output logic               term_tdqs
);
    //--------------------------------------------------------------
    // state
    //--------------------------------------------------------------
    dci_pkg::dci_pwr_t pwr_ff;
    dci_pkg::dci_bst_t bst_ff;
    logic              sr_ff;
    logic [7:0]        open_ff;
    logic [13:0]       row_ff [`DCI_BANKS];
    logic [13:0]       mr_ff [4];
    logic [2:0]        bnk_ff;
    logic [9:0]        col_ff;
    logic [2:0]        beat_ff;
    logic [2:0]        last_ff;
    logic              ap_ff;
    logic              il_ff;
    logic [26:0]       addr_ff;
    logic              we_ff;
    logic [7:0]        wd_ff;
    logic [7:0]        dq_ff;
    logic              oe_ff;
    logic              dqs_ff;
    logic              term_ff;

    //--------------------------------------------------------------
    // command decode
    //--------------------------------------------------------------
    // column of beat i in sequential or interleaved order
    function automatic logic [9:0] col_at(input logic [9:0] c, input logic [2:0] i,
                                          input logic il, input logic b4);
        logic [2:0] lo;
        lo = il ? (c[2:0] ^ i) : 3'(c[2:0] + i);
        if (b4)
            lo[2] = c[2];
        return {c[9:3], lo};
    endfunction

    wire dci_pkg::dci_cmd_t cmd_w = dci_pkg::dci_cmd_t'({pins.ras_n, pins.cas_n, pins.we_n});
    wire       awake_w  = pwr_ff == dci_pkg::DCI_PWR_ON && !sr_ff;
    wire       take_w   = !pins.cs_n && pins.cke && awake_w;
    wire       idle_w   = bst_ff == dci_pkg::DCI_BST_IDLE;
    wire       act_w    = take_w && cmd_w == dci_pkg::DCI_ACT;
    wire       pre_w    = take_w && cmd_w == dci_pkg::DCI_PRE;
    wire       mrs_w    = take_w && cmd_w == dci_pkg::DCI_MRS;
    wire       rd_w     = take_w && cmd_w == dci_pkg::DCI_RD && idle_w;
    wire       wr_w     = take_w && cmd_w == dci_pkg::DCI_WR && idle_w;
    wire       sre_w    = !pins.cs_n && !pins.cke && awake_w && idle_w && open_ff == 8'h00
                          && cmd_w == dci_pkg::DCI_REF;
    wire [1:0] blmode_w = mr_ff[0][`DCI_MR0_BL];
    wire       bc4_w    = blmode_w == `DCI_BL_BC4
                          || (blmode_w == `DCI_BL_OTF && !pins.a[`DCI_A_BC]);
    wire       last_w   = beat_ff == last_ff;
    wire       rtt_w    = pins.odt && !sr_ff
                          && (mr_ff[1][`DCI_MR1_RTT0] || mr_ff[1][`DCI_MR1_RTT1]
                          || mr_ff[1][`DCI_MR1_RTT2] || mr_ff[2][`DCI_MR2_RWR] != 2'h0);
    wire       mask_w   = !mr_ff[1][`DCI_MR1_TDQS] && pins.dm;
    wire [2:0] nbeat_w  = (bst_ff == dci_pkg::DCI_BST_RD) ? 3'(beat_ff + 3'h1) : beat_ff;
    wire [9:0] col_w    = col_at(col_ff, nbeat_w, il_ff, last_ff == `DCI_BC4_LAST);
    wire       sr_clr_n = pins.reset_n && !pins.cke;

    //--------------------------------------------------------------
    // self refresh flag, cleared by cke without a clock
    //--------------------------------------------------------------
    always_ff @(posedge pins.ck or negedge sr_clr_n)
    begin
        if (!sr_clr_n)
            sr_ff <= 1'b0;
        else if (sre_w)
            sr_ff <= 1'b1;
    end

    //--------------------------------------------------------------
    // power-down state from cke and open banks
    //--------------------------------------------------------------
    always_ff @(posedge pins.ck or negedge pins.reset_n)
    begin
        if (!pins.reset_n)
            pwr_ff <= dci_pkg::DCI_PWR_ON;
        else if (pins.cke)
            pwr_ff <= dci_pkg::DCI_PWR_ON;
        else if (awake_w && idle_w && !sre_w)
            pwr_ff <= (open_ff == 8'h00) ? dci_pkg::DCI_PWR_PPD : dci_pkg::DCI_PWR_APD;
    end

    //--------------------------------------------------------------
    // mode registers and open rows
    //--------------------------------------------------------------
    always_ff @(posedge pins.ck or negedge pins.reset_n)
    begin
        if (!pins.reset_n)
        begin
            open_ff <= 8'h00;
            for (int i = 0; i < 4; i++)
                mr_ff[i] <= `DCI_MR_RST;
            for (int b = 0; b < `DCI_BANKS; b++)
                row_ff[b] <= 14'h0000;
        end
        else
        begin
            if (mrs_w && !pins.ba[`DCI_BA_RFU])
                mr_ff[pins.ba[1:0]] <= pins.a;
            if (act_w)
            begin
                open_ff[pins.ba] <= 1'b1;
                row_ff[pins.ba]  <= pins.a;
            end
            else if (pre_w && pins.a[`DCI_A_AP])
                open_ff <= 8'h00;
            else if (pre_w)
                open_ff[pins.ba] <= 1'b0;
            else if (!idle_w && last_w && ap_ff)
                open_ff[bnk_ff] <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // burst engine
    //--------------------------------------------------------------
    always_ff @(posedge pins.ck or negedge pins.reset_n)
    begin
        if (!pins.reset_n)
        begin
            bst_ff  <= dci_pkg::DCI_BST_IDLE;
            beat_ff <= 3'h0;
            last_ff <= `DCI_BL8_LAST;
            bnk_ff  <= 3'h0;
            col_ff  <= 10'h000;
            ap_ff   <= 1'b0;
            il_ff   <= 1'b0;
        end
        else if (rd_w || wr_w)
        begin
            bst_ff  <= rd_w ? dci_pkg::DCI_BST_RD : dci_pkg::DCI_BST_WR;
            beat_ff <= 3'h0;
            last_ff <= bc4_w ? `DCI_BC4_LAST : `DCI_BL8_LAST;
            bnk_ff  <= pins.ba;
            col_ff  <= pins.a[9:0];
            ap_ff   <= pins.a[`DCI_A_AP];
            il_ff   <= mr_ff[0][`DCI_MR0_BT];
        end
        else if (!idle_w)
        begin
            beat_ff <= 3'(beat_ff + 3'h1);
            if (last_w)
                bst_ff <= dci_pkg::DCI_BST_IDLE;
        end
    end

    //--------------------------------------------------------------
    // array address and write beats
    //--------------------------------------------------------------
    always_ff @(posedge pins.ck or negedge pins.reset_n)
    begin
        if (!pins.reset_n)
        begin
            addr_ff <= 27'h0000000;
            we_ff   <= 1'b0;
            wd_ff   <= 8'h00;
        end
        else
        begin
            if (rd_w)
                addr_ff <= {pins.ba, row_ff[pins.ba], col_at(pins.a[9:0], 3'h0,
                            mr_ff[0][`DCI_MR0_BT], bc4_w)};
            else if (!idle_w)
                addr_ff <= {bnk_ff, row_ff[bnk_ff], col_w};
            we_ff <= bst_ff == dci_pkg::DCI_BST_WR && !mask_w;
            wd_ff <= pins.dq;
        end
    end

    //--------------------------------------------------------------
    // read drive and termination
    //--------------------------------------------------------------
    always_ff @(posedge pins.ck or negedge pins.reset_n)
    begin
        if (!pins.reset_n)
        begin
            dq_ff   <= 8'h00;
            oe_ff   <= 1'b0;
            dqs_ff  <= 1'b0;
            term_ff <= 1'b0;
        end
        else
        begin
            dq_ff   <= mem_rdata;
            oe_ff   <= bst_ff == dci_pkg::DCI_BST_RD;
            dqs_ff  <= (bst_ff == dci_pkg::DCI_BST_RD) ? !dqs_ff : 1'b0;
            term_ff <= rtt_w;
        end
    end

    // pin drivers and status
    assign pins.dev_dq_o    = dq_ff;
    assign pins.dev_dq_oe   = oe_ff;
    assign pins.dev_dqs_o   = dqs_ff;
    assign pins.dev_dqs_n_o = !dqs_ff;
    assign mem_addr         = addr_ff;
    assign mem_we           = we_ff;
    assign mem_wdata        = wd_ff;
    assign bank_open        = open_ff;
    assign pwr_state        = sr_ff ? dci_pkg::DCI_PWR_SREF : pwr_ff;
    assign term_en          = term_ff;
    assign term_tdqs        = term_ff && mr_ff[1][`DCI_MR1_TDQS];
endmodule

// ### rtl/dci_ctrl_end.sv
// controller end of the ddr3 command pin link: clock divider, command issue, data beats
`timescale 1ns/10ps
`include "dci_params.svh"
module dci_ctrl_end (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // link pins
    dci_link_if.ctl                pins,
    // command request
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire dci_pkg::dci_cmd_t req_cmd,
    input  wire logic [2:0]        req_ba,
    input  wire logic [13:0]       req_a,
    input  wire logic [2:0]        req_last,
    input  wire logic [63:0]       wr_data,
    input  wire logic [7:0]        wr_mask,
    // pin levels between requests
    input  wire logic              cke_req,
    input  wire logic              odt_req,
    // read answer
    output logic [63:0]            rd_data,
    output logic                   rd_valid
);
    dci_pkg::dci_cst_t st_ff;
    logic [2:0]  cnt_ff;
    logic        ck_ff;
    logic        rst_n_ff;
    logic [3:0]  beat_ff;
    logic [2:0]  last_ff;
    logic [63:0] wd_ff;
    logic [7:0]  wm_ff;
    logic [3:0]  cmd_ff;
    logic [2:0]  ba_ff;
    logic [13:0] a_ff;
    logic        cke_ff;
    logic        odt_ff;
    logic [7:0]  dq_ff;
    logic        dm_ff;
    logic        oe_ff;
    logic        dqs_ff;
    logic [63:0] rd_ff;
    logic        rv_ff;
    logic [7:0]  dq_s;

    // read data sampled into sys_clk
    dci_sync #(.W(8)) u_dq_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .d       (pins.dq),
        .q       (dq_s)
    );

    // ticks of the divided link clock
    wire       wrap_w = cnt_ff == `DCI_CK_HALF_LAST;
    wire       fall_w = wrap_w && ck_ff;
    wire       rise_w = wrap_w && !ck_ff;
    wire       cap_w  = !ck_ff && cnt_ff == `DCI_CAP_CNT;
    wire [3:0] ridx_w = 4'(beat_ff - `DCI_RD_SKIP);
    wire       rcap_w = st_ff == dci_pkg::DCI_CST_RD && cap_w && beat_ff >= `DCI_RD_SKIP;
    // commands only go out with cke already high, so power-down has exited first
    assign req_ready = st_ff == dci_pkg::DCI_CST_IDLE && fall_w && cke_ff;
    wire       take_w = req_valid && req_ready;
    // cke follows the request level, held through a command, forced high in bursts
    wire       nxt_cke = (st_ff == dci_pkg::DCI_CST_CMD) ? cke_ff
                         : (cke_req || st_ff != dci_pkg::DCI_CST_IDLE);

    // divider and reset pin
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_ff   <= 3'h0;
            ck_ff    <= 1'b0;
            rst_n_ff <= 1'b0;
        end
        else
        begin
            cnt_ff   <= wrap_w ? 3'h0 : 3'(cnt_ff + 3'h1);
            ck_ff    <= wrap_w ? !ck_ff : ck_ff;
            rst_n_ff <= 1'b1;
        end
    end

    // command pins and state updated on falling ck, state also at the last read capture
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_ff   <= dci_pkg::DCI_CST_IDLE;
            cmd_ff  <= {1'b1, dci_pkg::DCI_NOP};
            ba_ff   <= 3'h0;
            a_ff    <= 14'h0000;
            cke_ff  <= 1'b0;
            odt_ff  <= 1'b0;
            beat_ff <= 4'h0;
            last_ff <= `DCI_BL8_LAST;
            wd_ff   <= 64'h0;
            wm_ff   <= 8'h00;
        end
        else if (take_w)
        begin
            cmd_ff  <= {1'b0, req_cmd};
            ba_ff   <= req_ba;
            a_ff    <= req_a;
            cke_ff  <= cke_req;
            odt_ff  <= odt_req;
            beat_ff <= 4'h0;
            last_ff <= req_last;
            wd_ff   <= wr_data;
            wm_ff   <= wr_mask;
            unique case (req_cmd)
                dci_pkg::DCI_WR: st_ff <= dci_pkg::DCI_CST_WR;
                dci_pkg::DCI_RD: st_ff <= dci_pkg::DCI_CST_RD;
                default:         st_ff <= dci_pkg::DCI_CST_CMD;
            endcase
        end
        else if (fall_w)
        begin
            cmd_ff <= {1'b1, dci_pkg::DCI_NOP};
            cke_ff <= nxt_cke;
            odt_ff <= odt_req;
            if (st_ff != dci_pkg::DCI_CST_IDLE)
                beat_ff <= 4'(beat_ff + 4'h1);
            if (st_ff == dci_pkg::DCI_CST_CMD
                || (st_ff == dci_pkg::DCI_CST_WR && beat_ff == 4'({1'b0, last_ff} + 4'h1)))
                st_ff <= dci_pkg::DCI_CST_IDLE;
        end
        else if (rcap_w && ridx_w[2:0] == last_ff)
            st_ff <= dci_pkg::DCI_CST_IDLE;
    end

    // write beats on falling ck, strobe toggles on rising ck
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dq_ff  <= 8'h00;
            dm_ff  <= 1'b0;
            oe_ff  <= 1'b0;
            dqs_ff <= 1'b0;
        end
        else
        begin
            if (fall_w)
            begin
                oe_ff <= st_ff == dci_pkg::DCI_CST_WR && beat_ff <= {1'b0, last_ff};
                dq_ff <= wd_ff[beat_ff[2:0]*8 +: 8];
                dm_ff <= wm_ff[beat_ff[2:0]];
            end
            if (rise_w)
                dqs_ff <= oe_ff && !dqs_ff;
        end
    end

    // read beats gathered into one word
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_ff <= 64'h0;
            rv_ff <= 1'b0;
        end
        else
        begin
            if (rcap_w)
                rd_ff[ridx_w[2:0]*8 +: 8] <= dq_s;
            rv_ff <= rcap_w && ridx_w[2:0] == last_ff;
        end
    end

    // pin drivers
    assign pins.ck          = ck_ff;
    assign pins.reset_n     = rst_n_ff;
    assign pins.cs_n        = cmd_ff[3];
    assign pins.ras_n       = cmd_ff[2];
    assign pins.cas_n       = cmd_ff[1];
    assign pins.we_n        = cmd_ff[0];
    assign pins.ba          = ba_ff;
    assign pins.a           = a_ff;
    assign pins.cke         = cke_ff;
    assign pins.odt         = odt_ff;
    assign pins.dm          = dm_ff;
    assign pins.ctl_dq_o    = dq_ff;
    assign pins.ctl_dq_oe   = oe_ff;
    assign pins.ctl_dqs_o   = dqs_ff;
    assign pins.ctl_dqs_n_o = !dqs_ff;
    assign rd_data          = rd_ff;
    assign rd_valid         = rv_ff;
endmodule

// ### testbench/dci_link_checker.sv
// assertions on the pins between the two ends of the dram link
`timescale 1ns/10ps
module dci_link_checker (
    // link clock and reset
    input wire logic       ck,
    input wire logic       ck_n,
    input wire logic       reset_n,
    // command pins
    input wire logic       cke,
    input wire logic       cs_n,
    input wire logic       ras_n,
    input wire logic       cas_n,
    input wire logic       we_n,
    input wire logic [2:0] ba,
    // strobes and data drivers
    input wire logic       dqs,
    input wire logic       dqs_n,
    input wire logic       dev_dq_oe,
    input wire logic       ctl_dq_oe
);
    default clocking cb @(posedge ck);
    endclocking
    default disable iff (!reset_n);
    // command decode at the pins
    wire logic [2:0] cmd_code = {ras_n, cas_n, we_n};
    wire logic       rd_cmd   = !cs_n && cke && cmd_code == dci_pkg::DCI_RD;
    wire logic       mrs_cmd  = !cs_n && cke && cmd_code == dci_pkg::DCI_MRS;
    wire logic       drive_on = dev_dq_oe || ctl_dq_oe;
    // link properties
    property p_ck_pair; ck_n != ck; endproperty
    a_ck_pair: assert property (p_ck_pair) else $error("ck pair not opposite");
    property p_rd_answer; rd_cmd |-> ##2 dev_dq_oe; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_len;
        $rose(dev_dq_oe) |-> dev_dq_oe[*4] ##1 (!dev_dq_oe or dev_dq_oe[*4] ##1 !dev_dq_oe);
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("read burst not 4 or 8");
    property p_rd_first; $rose(dev_dq_oe) |-> dqs; endproperty
    a_rd_first: assert property (p_rd_first) else $error("first strobe low");
    property p_rd_toggle; dev_dq_oe && $past(dev_dq_oe) |-> dqs != $past(dqs); endproperty
    a_rd_toggle: assert property (p_rd_toggle) else $error("strobe stuck");
    property p_strobe_pair; drive_on |-> dqs_n != dqs; endproperty
    a_strobe_pair: assert property (p_strobe_pair) else $error("strobe not paired");
    property p_cke_held; drive_on |-> cke; endproperty
    a_cke_held: assert property (p_cke_held) else $error("cke low in burst");
    property p_mrs_rfu; mrs_cmd |-> ba[2] == 1'b0; endproperty
    a_mrs_rfu: assert property (p_mrs_rfu) else $error("mode set with ba2");
    // main scenarios seen
    c_read: cover property ($rose(dev_dq_oe));
    c_write: cover property ($rose(ctl_dq_oe));
    c_mrs: cover property (mrs_cmd);
endmodule

// ### testbench/test_ddr3_sdram_command_pin_interface.sv
// bench for both ends of the dram command pin link
`timescale 1ns/10ps
module test_ddr3_sdram_command_pin_interface;
    // user side, status and memory array
    logic              sys_clk = 1'b0, sys_rst = 1'b1;
    logic              req_valid = 1'b0, cke_req = 1'b1, odt_req = 1'b0;
    logic              req_ready, rd_valid, mem_we, term_en, term_tdqs;
    logic [2:0]        req_ba = 3'h0, req_last = 3'h7;
    logic [13:0]       req_a = 14'h0000;
    logic [63:0]       wr_data = 64'h0, rd_data, d;
    logic [7:0]        wr_mask = 8'h00, mem_wdata, mem_rdata, bank_open;
    logic [7:0]        mem [256];
    logic [26:0]       mem_addr;
    dci_pkg::dci_cmd_t req_cmd = dci_pkg::DCI_NOP;
    dci_pkg::dci_pwr_t pwr_state;
    int                errors = 0, compares = 0;
    // both ends joined by the link
    dci_link_if dci_link_if_inst ();
    dci_ctrl_end dci_ctrl_end_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .pins(dci_link_if_inst),
        .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_ba(req_ba),
        .req_a(req_a), .req_last(req_last), .wr_data(wr_data), .wr_mask(wr_mask),
        .cke_req(cke_req), .odt_req(odt_req), .rd_data(rd_data), .rd_valid(rd_valid)
    );
    dci_dram_end dci_dram_end_inst (
        .pins(dci_link_if_inst), .mem_addr(mem_addr), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .pwr_state(pwr_state),
        .bank_open(bank_open), .term_en(term_en), .term_tdqs(term_tdqs)
    );
    dci_link_checker dci_link_checker_inst (
        .ck(dci_link_if_inst.ck), .ck_n(dci_link_if_inst.ck_n),
        .reset_n(dci_link_if_inst.reset_n), .cke(dci_link_if_inst.cke),
        .cs_n(dci_link_if_inst.cs_n), .ras_n(dci_link_if_inst.ras_n),
        .cas_n(dci_link_if_inst.cas_n), .we_n(dci_link_if_inst.we_n),
        .ba(dci_link_if_inst.ba), .dqs(dci_link_if_inst.dqs),
        .dqs_n(dci_link_if_inst.dqs_n), .dev_dq_oe(dci_link_if_inst.dev_dq_oe),
        .ctl_dq_oe(dci_link_if_inst.ctl_dq_oe)
    );
    // array behind the dram end, read in the same link cycle
    initial
        for (int i = 0; i < 256; i++)
            mem[i] = ~8'(i);
    always @(posedge dci_link_if_inst.ck)
        if (mem_we === 1'b1)
            mem[mem_addr[7:0]] <= mem_wdata;
    assign mem_rdata = mem[mem_addr[7:0]];
    // system clock
    initial forever #2 sys_clk = ~sys_clk;
    // verdict and end of run
    task automatic wrap_up(input int hung);
        errors += hung;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, g);
        compares++;
        if (g !== e)
            $display("Error %s expected %h seen %h", nm, e, g);
        errors += (g !== e);
    endtask
    task automatic wt;
        repeat (40) @(posedge sys_clk);
        #1;
    endtask
    // one request, held until taken
    task automatic req(input dci_pkg::dci_cmd_t c, input logic [2:0] b, input logic [13:0] ad);
        int n;
        @(posedge sys_clk) #1;
        req_cmd = c;
        req_ba = b;
        req_a = ad;
        req_valid = 1'b1;
        for (n = 0; n < 300 && req_ready !== 1'b1; n++) @(posedge sys_clk) #1;
        if (n == 300)
            wrap_up(1);
        @(posedge sys_clk) #1 req_valid = 1'b0;
    endtask
    task automatic rd(input logic [13:0] ad);
        int n;
        req(dci_pkg::DCI_RD, 3'h3, ad);
        for (n = 0; n < 300 && rd_valid !== 1'b1; n++) @(posedge sys_clk) #1;
        if (n == 300)
            wrap_up(1);
        d = rd_data;
    endtask
    // test sequence
    initial
    begin
        repeat (5) @(posedge sys_clk) #1;
        sys_rst = 1'b0;
        odt_req = 1'b1;
        req(dci_pkg::DCI_MRS, 3'h1, 14'h0804);
        wt();
        chk("term_en", 1, term_en);
        chk("term_tdqs", 1, term_tdqs);
        req(dci_pkg::DCI_MRS, 3'h1, 14'h0000);
        wt();
        chk("term_en off", 0, term_en);
        odt_req = 1'b0;
        req(dci_pkg::DCI_MRS, 3'h0, 14'h0001);
        $display("test modes done");
        req(dci_pkg::DCI_ACT, 3'h3, 14'h0005);
        wt();
        chk("bank_open act", 8'h08, bank_open);
        wr_data = 64'h8877665544332211;
        wr_mask = 8'h04;
        req(dci_pkg::DCI_WR, 3'h3, 14'h1008);
        rd(14'h1408);
        chk("rd_data bl8", 64'h8877665544F52211, d);
        wt();
        chk("bank_open ap", 8'h00, bank_open);
        req(dci_pkg::DCI_ACT, 3'h3, 14'h0005);
        req_last = 3'h3;
        rd(14'h0008);
        chk("rd_data bc4", 32'h44F52211, d[31:0]);
        req(dci_pkg::DCI_MRS, 3'h0, 14'h000A);
        rd(14'h0009);
        chk("rd_data il bc4", 32'hF5441122, d[31:0]);
        req_last = 3'h7;
        $display("test bursts done");
        req(dci_pkg::DCI_ACT, 3'h5, 14'h0000);
        req(dci_pkg::DCI_PRE, 3'h3, 14'h0000);
        wt();
        chk("bank_open pre", 8'h20, bank_open);
        cke_req = 1'b0;
        wt();
        chk("pwr active", 2, pwr_state);
        cke_req = 1'b1;
        req(dci_pkg::DCI_PRE, 3'h0, 14'h0400);
        wt();
        chk("bank_open all", 8'h00, bank_open);
        cke_req = 1'b0;
        wt();
        chk("pwr precharge", 1, pwr_state);
        cke_req = 1'b1;
        req(dci_pkg::DCI_PRE, 3'h0, 14'h0400);
        cke_req = 1'b0;
        req(dci_pkg::DCI_REF, 3'h0, 14'h0000);
        wt();
        chk("pwr self refresh", 3, pwr_state);
        cke_req = 1'b1;
        req(dci_pkg::DCI_ACT, 3'h2, 14'h0001);
        wt();
        chk("pwr on", 0, pwr_state);
        sys_rst = 1'b1;
        repeat (5) @(posedge sys_clk) #1;
        chk("bank_open reset", 8'h00, bank_open);
        sys_rst = 1'b0;
        $display("test power done");
        wrap_up(0);
    end
endmodule
